/* File: shared/bus_monitor_pkg.sv */
// Purpose: Shared constants for the TDM backplane status and interrupt block
// Assumes: 10 MHz system clock; 32-bit Avalon-MM data, byte addressing
// Notes:   Register byte address is four times the register index
package bus_monitor_pkg;

    // ==========================================================================
    // Register map
    // ==========================================================================
    localparam int          ADDR_W             = 14;
    localparam logic [11:0] IDX_STATUS         = 12'h702;
    localparam logic [11:0] IDX_IRQ_ENABLE     = 12'h704;
    localparam logic [11:0] IDX_STATUS_CLEAR   = 12'h706;
    localparam logic [11:0] IDX_COUNT_HIGH     = 12'h708;
    localparam logic [11:0] IDX_COUNT_LOW      = 12'h70A;
    localparam logic [11:0] IDX_ALARM0_COMPARE = 12'h70C;
    localparam logic [11:0] IDX_ALARM1_COMPARE = 12'h70E;

    localparam logic [13:0] ADDR_STATUS         = {IDX_STATUS, 2'b00};
    localparam logic [13:0] ADDR_IRQ_ENABLE     = {IDX_IRQ_ENABLE, 2'b00};
    localparam logic [13:0] ADDR_STATUS_CLEAR   = {IDX_STATUS_CLEAR, 2'b00};
    localparam logic [13:0] ADDR_COUNT_HIGH     = {IDX_COUNT_HIGH, 2'b00};
    localparam logic [13:0] ADDR_COUNT_LOW      = {IDX_COUNT_LOW, 2'b00};
    localparam logic [13:0] ADDR_ALARM0_COMPARE = {IDX_ALARM0_COMPARE, 2'b00};
    localparam logic [13:0] ADDR_ALARM1_COMPARE = {IDX_ALARM1_COMPARE, 2'b00};

    // ==========================================================================
    // Status bit positions
    // ==========================================================================
    localparam int BIT_ALARM0        = 0;
    localparam int BIT_ALARM1        = 1;
    localparam int BIT_FRAME_A       = 2;
    localparam int BIT_FRAME_B       = 3;
    localparam int BIT_CLOCK_A       = 4;
    localparam int BIT_CLOCK_B       = 5;
    localparam int BIT_POINT_LOST_A  = 6;
    localparam int BIT_POINT_LOST_B  = 7;
    localparam int BIT_FRAMING_LOST  = 8;
    localparam int BIT_FRAME_A_COPY  = 12;
    localparam int BIT_FRAME_B_COPY  = 13;
    localparam int BIT_CLOCK_A_COPY  = 14;
    localparam int BIT_CLOCK_B_COPY  = 15;

    // ==========================================================================
    // Reset values and masks
    // ==========================================================================
    localparam logic [15:0] STATUS_RESET      = 16'h0100;
    localparam logic [15:0] ENABLE_RESET      = 16'h0000;
    localparam logic [15:0] COMPARE_RESET     = 16'h0000;
    localparam logic [31:0] COUNTER_RESET     = 32'h00000000;
    localparam logic [15:0] STATUS_IMPL_MASK  = 16'hF1FF;

    // ==========================================================================
    // Timing
    // ==========================================================================
    localparam int CLK_PERIOD_NS       = 100;
    localparam int LINK_PERIOD_NS      = 800;
    localparam int CLOCK_TOL_NS        = 35;
    localparam int CLOCK_TOL_CYCLES    = (CLOCK_TOL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FRAME_WINDOW_CYCLES = 1024;

    // ==========================================================================
    // Bus slave states
    // ==========================================================================
    typedef enum logic [0:0] {
        BUS_IDLE   = 1'b0,
        BUS_ANSWER = 1'b1
    } bus_state_e;

endpackage

/* File: core/backplane_line_checker.sv */
// Purpose: Watches one backplane bus: frame pulse presence and 8 MHz clock spacing
// Assumes: Both pins are asynchronous to clk_in and are synchronised here
// Notes:   Fault outputs are one-cycle pulses on clk_in
`timescale 1ns/1ns
module backplane_line_checker #(
    parameter int EXP_CYCLES   = 8,
    parameter int TOL_CYCLES   = 1,
    parameter int FRAME_WINDOW = 1024
) (
    // Clock and reset
    input  wire logic clk_in,
    input  wire logic sys_rst_in,
    // Backplane pins
    input  wire logic frame_pulse_n_in,
    input  wire logic clock_8mhz_in,
    // Fault events
    output logic      frame_fault_out,
    output logic      clock_fault_out
);

    localparam logic [15:0] MIN_GAP   = 16'(EXP_CYCLES - TOL_CYCLES);
    localparam logic [15:0] MAX_GAP   = 16'(EXP_CYCLES + TOL_CYCLES);
    localparam logic [10:0] FRAME_END = 11'(FRAME_WINDOW - 1);

    logic [2:0]  clk_sync_q;
    logic [1:0]  frm_sync_q;
    logic [15:0] gap_q;
    logic        armed_q;
    logic [10:0] frame_cnt_q;
    logic        frame_fault_q;
    logic        clock_fault_q;

    // ==========================================================================
    // Synchronisers and edge finding
    // ==========================================================================
    wire         link_rise = clk_sync_q[1] & ~clk_sync_q[2];
    wire         frame_low = ~frm_sync_q[1];
    wire  [15:0] gap_now   = gap_q + 16'h0001;
    wire         gap_bad   = (gap_now < MIN_GAP) || (gap_now > MAX_GAP);
    wire         timed_out = ~link_rise && armed_q && (gap_now > MAX_GAP);

    // Two flops per pin, a third stage only for the clock edge
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            clk_sync_q <= 3'h0;
            frm_sync_q <= 2'h3;
        end else begin
            clk_sync_q <= {clk_sync_q[1:0], clock_8mhz_in};
            frm_sync_q <= {frm_sync_q[0], frame_pulse_n_in};
        end
    end

    // ==========================================================================
    // Clock spacing check
    // ==========================================================================
    // Edge too early, too late, or missing altogether
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            gap_q         <= 16'h0000;
            armed_q       <= 1'b0;
            clock_fault_q <= 1'b0;
        end else begin
            clock_fault_q <= (link_rise && armed_q && gap_bad) || timed_out;
            if (link_rise) begin
                gap_q   <= 16'h0000;
                armed_q <= 1'b1;
            end else if (timed_out) begin
                armed_q <= 1'b0;
            end else if (gap_q != 16'hFFFF) begin
                gap_q   <= gap_now;
            end
        end
    end

    // ==========================================================================
    // Frame presence check
    // ==========================================================================
    // Count link clock edges since the frame pulse was last seen low
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            frame_cnt_q   <= 11'h000;
            frame_fault_q <= 1'b0;
        end else begin
            frame_fault_q <= 1'b0;
            if (link_rise) begin
                if (frame_low) begin
                    frame_cnt_q <= 11'h000;
                end else if (frame_cnt_q == FRAME_END) begin
                    frame_cnt_q   <= 11'h000;
                    frame_fault_q <= 1'b1;
                end else begin
                    frame_cnt_q <= frame_cnt_q + 11'h001;
                end
            end
        end
    end

    assign frame_fault_out = frame_fault_q;
    assign clock_fault_out = clock_fault_q;

endmodule

/* File: core/tdm_bus_monitor_status_irq.sv */
// Purpose: Status, alarm and interrupt logic for the TDM backplane interface
// Assumes: clk_in is the memory clock; registers reached over Avalon-MM
// Notes:   Each access takes one wait state; status flags clear on write of 1
//
// The implementer's own choice: register access over Avalon-MM.
`timescale 1ns/1ns
module tdm_bus_monitor_status_irq #(
    parameter int LINK_PERIOD_NS = bus_monitor_pkg::LINK_PERIOD_NS,
    parameter int FRAME_WINDOW   = bus_monitor_pkg::FRAME_WINDOW_CYCLES
) (
    // Clock and reset
    input  wire logic        clk_in,
    input  wire logic        sys_rst_in,
    // Avalon-MM slave
    input  wire logic [13:0] avs_address_in,
    input  wire logic        avs_read_in,
    input  wire logic        avs_write_in,
    input  wire logic [31:0] avs_writedata_in,
    input  wire logic [3:0]  avs_byteenable_in,
    output logic      [31:0] avs_readdata_out,
    output logic             avs_waitrequest_out,
    // Backplane pins
    input  wire logic        bus_a_frame_pulse_in,
    input  wire logic        bus_b_frame_pulse_in,
    input  wire logic        bus_a_8mhz_clock_in,
    input  wire logic        bus_b_8mhz_clock_in,
    // Adaptive modules and slave framer
    input  wire logic        adap_a_point_lost_in,
    input  wire logic        adap_b_point_lost_in,
    input  wire logic        slave_sync_loss_in,
    // Outputs to the TDM data pins and the host
    output logic             tdm_data_oe_out,
    output logic             irq_out
);

    localparam int EXP_CYCLES =
        LINK_PERIOD_NS / bus_monitor_pkg::CLK_PERIOD_NS;

    // ==========================================================================
    // Declarations
    // ==========================================================================
    bus_monitor_pkg::bus_state_e state_q;
    bus_monitor_pkg::bus_state_e state_d;

    logic [31:0] counter_q;
    logic [15:0] status_q;
    logic [15:0] status_d;
    logic [15:0] enable_q;
    logic [15:0] alarm0_cmp_q;
    logic [15:0] alarm1_cmp_q;
    logic        match0_q;
    logic        match1_q;
    logic [31:0] readdata_q;
    logic        data_oe_q;

    wire  [1:0]  frame_pins = {bus_b_frame_pulse_in, bus_a_frame_pulse_in};
    wire  [1:0]  clock_pins = {bus_b_8mhz_clock_in, bus_a_8mhz_clock_in};
    wire  [1:0]  frame_fault;
    wire  [1:0]  clock_fault;

    // ==========================================================================
    // Per-bus line checkers
    // ==========================================================================
    // One checker per backplane bus, A at index 0 and B at index 1
    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : gen_bus
            backplane_line_checker #(
                .EXP_CYCLES   (EXP_CYCLES),
                .TOL_CYCLES   (bus_monitor_pkg::CLOCK_TOL_CYCLES),
                .FRAME_WINDOW (FRAME_WINDOW)
            ) u_checker (
                .clk_in           (clk_in),
                .sys_rst_in       (sys_rst_in),
                .frame_pulse_n_in (frame_pins[g]),
                .clock_8mhz_in    (clock_pins[g]),
                .frame_fault_out  (frame_fault[g]),
                .clock_fault_out  (clock_fault[g])
            );
        end
    endgenerate

    // ==========================================================================
    // Bus slave handshake
    // ==========================================================================
    // Request seen, answer one cycle later
    wire        bus_req    = avs_read_in | avs_write_in;
    wire        bus_commit = bus_req && (state_q == bus_monitor_pkg::BUS_ANSWER);
    wire        wr_commit  = bus_commit && avs_write_in;
    wire        rd_capture = avs_read_in && (state_q == bus_monitor_pkg::BUS_IDLE);

    // Handshake state
    always_comb begin
        case (state_q)
            bus_monitor_pkg::BUS_IDLE: begin
                state_d = bus_req ? bus_monitor_pkg::BUS_ANSWER : bus_monitor_pkg::BUS_IDLE;
            end
            bus_monitor_pkg::BUS_ANSWER: begin
                state_d = bus_monitor_pkg::BUS_IDLE;
            end
            default: begin
                state_d = bus_monitor_pkg::BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            state_q <= bus_monitor_pkg::BUS_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    assign avs_waitrequest_out = bus_req && (state_q != bus_monitor_pkg::BUS_ANSWER);

    // ==========================================================================
    // Address decode and write data
    // ==========================================================================
    // Only the low two byte lanes carry register bits
    wire [15:0] lane_mask = {{8{avs_byteenable_in[1]}}, {8{avs_byteenable_in[0]}}};
    wire [15:0] wr_bits   = avs_writedata_in[15:0] & lane_mask;

    wire sel_status  = (avs_address_in == bus_monitor_pkg::ADDR_STATUS);
    wire sel_enable  = (avs_address_in == bus_monitor_pkg::ADDR_IRQ_ENABLE);
    wire sel_clear   = (avs_address_in == bus_monitor_pkg::ADDR_STATUS_CLEAR);
    wire sel_cnt_hi  = (avs_address_in == bus_monitor_pkg::ADDR_COUNT_HIGH);
    wire sel_cnt_lo  = (avs_address_in == bus_monitor_pkg::ADDR_COUNT_LOW);
    wire sel_alarm0  = (avs_address_in == bus_monitor_pkg::ADDR_ALARM0_COMPARE);
    wire sel_alarm1  = (avs_address_in == bus_monitor_pkg::ADDR_ALARM1_COMPARE);

    wire wr_status   = wr_commit && sel_status;
    wire wr_enable   = wr_commit && sel_enable;
    wire wr_clear    = wr_commit && sel_clear;
    wire wr_alarm0   = wr_commit && sel_alarm0;
    wire wr_alarm1   = wr_commit && sel_alarm1;

    // ==========================================================================
    // Free-running memory clock counter
    // ==========================================================================
    // Wraps freely, no enable
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            counter_q <= bus_monitor_pkg::COUNTER_RESET;
        end else begin
            counter_q <= counter_q + 32'h00000001;
        end
    end

    // ==========================================================================
    // Interval alarms
    // ==========================================================================
    // Compare against the counter's upper half
    wire match0      = (counter_q[31:16] == alarm0_cmp_q);
    wire match1      = (counter_q[31:16] == alarm1_cmp_q);
    wire alarm0_hit  = match0 & ~match0_q;
    wire alarm1_hit  = match1 & ~match1_q;

    // Compare values and match history; history starts high so reset is quiet
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            alarm0_cmp_q <= bus_monitor_pkg::COMPARE_RESET;
            alarm1_cmp_q <= bus_monitor_pkg::COMPARE_RESET;
            match0_q     <= 1'b1;
            match1_q     <= 1'b1;
        end else begin
            match0_q <= match0;
            match1_q <= match1;
            if (wr_alarm0) begin
                alarm0_cmp_q <= (alarm0_cmp_q & ~lane_mask) | wr_bits;
            end
            if (wr_alarm1) begin
                alarm1_cmp_q <= (alarm1_cmp_q & ~lane_mask) | wr_bits;
            end
        end
    end

    // ==========================================================================
    // Status flag sources
    // ==========================================================================
    // Primary fault bits also knock the slave out of framing
    wire        line_fault   = |frame_fault | |clock_fault;
    wire        framing_loss = slave_sync_loss_in | line_fault;

    wire [15:0] status_set;
    assign status_set[bus_monitor_pkg::BIT_ALARM0]       = alarm0_hit;
    assign status_set[bus_monitor_pkg::BIT_ALARM1]       = alarm1_hit;
    assign status_set[bus_monitor_pkg::BIT_FRAME_A]      = frame_fault[0];
    assign status_set[bus_monitor_pkg::BIT_FRAME_B]      = frame_fault[1];
    assign status_set[bus_monitor_pkg::BIT_CLOCK_A]      = clock_fault[0];
    assign status_set[bus_monitor_pkg::BIT_CLOCK_B]      = clock_fault[1];
    assign status_set[bus_monitor_pkg::BIT_POINT_LOST_A] = adap_a_point_lost_in;
    assign status_set[bus_monitor_pkg::BIT_POINT_LOST_B] = adap_b_point_lost_in;
    assign status_set[bus_monitor_pkg::BIT_FRAMING_LOST] = framing_loss;
    assign status_set[11:9]                              = 3'h0;
    // Copies see the same detections, read back in status and feed the interrupt through their enable bits
    assign status_set[bus_monitor_pkg::BIT_FRAME_A_COPY] = frame_fault[0];
    assign status_set[bus_monitor_pkg::BIT_FRAME_B_COPY] = frame_fault[1];
    assign status_set[bus_monitor_pkg::BIT_CLOCK_A_COPY] = clock_fault[0];
    assign status_set[bus_monitor_pkg::BIT_CLOCK_B_COPY] = clock_fault[1];

    // ==========================================================================
    // Status register
    // ==========================================================================
    // Write of one clears, either at the status or the clear address
    wire [15:0] status_clr = (wr_status || wr_clear) ? wr_bits : 16'h0000;

    // A new event in the clearing cycle wins over the clear
    always_comb begin
        status_d = ((status_q & ~status_clr) | status_set)
                   & bus_monitor_pkg::STATUS_IMPL_MASK;
    end

    // Framing lost comes up set out of reset
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            status_q <= bus_monitor_pkg::STATUS_RESET;
        end else begin
            status_q <= status_d;
        end
    end

    // ==========================================================================
    // Interrupt enable and output
    // ==========================================================================
    // Reserved enable bits are never stored
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            enable_q <= bus_monitor_pkg::ENABLE_RESET;
        end else if (wr_enable) begin
            enable_q <= ((enable_q & ~lane_mask) | wr_bits)
                        & bus_monitor_pkg::STATUS_IMPL_MASK;
        end
    end

    // Level interrupt while any enabled flag stands
    assign irq_out = |(status_q & enable_q);

    // ==========================================================================
    // TDM data pin enable
    // ==========================================================================
    // Data pins float while the slave has lost framing
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            data_oe_q <= 1'b0;
        end else begin
            data_oe_q <= ~status_d[bus_monitor_pkg::BIT_FRAMING_LOST];
        end
    end

    assign tdm_data_oe_out = data_oe_q;

    // ==========================================================================
    // Read path
    // ==========================================================================
    // Clear register reads zero; unmapped addresses read zero
    wire [15:0] rd_mux =
        sel_status ? status_q :
        sel_enable ? enable_q :
        sel_cnt_hi ? counter_q[31:16] :
        sel_cnt_lo ? counter_q[15:0] :
        sel_alarm0 ? alarm0_cmp_q :
        sel_alarm1 ? alarm1_cmp_q :
        16'h0000;

    // Data captured in the first cycle and held through the answer
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            readdata_q <= 32'h00000000;
        end else if (rd_capture) begin
            readdata_q <= {16'h0000, rd_mux};
        end
    end

    assign avs_readdata_out = readdata_q;

endmodule

/* File: tb/tdm_bus_monitor_status_irq_assertions.sv */
// Purpose: Port checks for the status block
// Assumes: One wait state per bus access
// Notes:   Bound into the top module
`timescale 1ns/1ns
module tdm_bus_monitor_status_irq_checker (
    input wire logic        clk_in,
    input wire logic        sys_rst_in,
    input wire logic [13:0] avs_address_in,
    input wire logic        avs_read_in,
    input wire logic        avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [31:0] avs_readdata_out,
    input wire logic        avs_waitrequest_out,
    input wire logic        slave_sync_loss_in,
    input wire logic        tdm_data_oe_out,
    input wire logic        irq_out
);
    // ====================
    // Decodes and properties
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);
    // Commit edges and register selects
    wire commit_w    = avs_write_in && !avs_waitrequest_out;
    wire read_done   = avs_read_in && !avs_waitrequest_out;
    wire stat_sel    = (avs_address_in == bus_monitor_pkg::ADDR_STATUS);
    wire clr_sel     = (avs_address_in == bus_monitor_pkg::ADDR_STATUS_CLEAR);
    wire en_sel      = (avs_address_in == bus_monitor_pkg::ADDR_IRQ_ENABLE);
    wire frame_clear = commit_w && (stat_sel || clr_sel) && avs_writedata_in[8];

    wait_state_a: assert property (($rose(avs_read_in) || $rose(avs_write_in)) |->
        avs_waitrequest_out ##1 !avs_waitrequest_out) else $error("wait state count wrong");
    upper_zero_a: assert property (read_done |-> avs_readdata_out[31:16] == 16'h0000)
        else $error("upper read half not zero");
    reserved_zero_a: assert property (read_done && (stat_sel || en_sel) |->
        avs_readdata_out[11:9] == 3'h0) else $error("reserved bits read nonzero");
    loss_tristate_a: assert property (slave_sync_loss_in |-> ##[1:2] !tdm_data_oe_out)
        else $error("pins driven after framing loss");
    startup_oe_a: assert property ($fell(sys_rst_in) |-> !tdm_data_oe_out)
        else $error("data pins driven at start-up");
    oe_release_a: assert property ($rose(tdm_data_oe_out) |->
        $past(frame_clear) || $past(frame_clear, 2)) else $error("pins on without a clear");
    irq_fall_a: assert property ($fell(irq_out) |-> $past(commit_w))
        else $error("irq fell without a write");
    startup_irq_a: assert property ($fell(sys_rst_in) |-> !irq_out)
        else $error("irq high after reset");

    // Main scenarios reached
    oe_on_c: cover property ($rose(tdm_data_oe_out));
    oe_off_c: cover property ($fell(tdm_data_oe_out));
    irq_on_c: cover property ($rose(irq_out));
endmodule

bind tdm_bus_monitor_status_irq tdm_bus_monitor_status_irq_checker u_chk (.clk_in, .sys_rst_in,
    .avs_address_in, .avs_read_in, .avs_write_in, .avs_writedata_in, .avs_readdata_out,
    .avs_waitrequest_out, .slave_sync_loss_in, .tdm_data_oe_out, .irq_out);

/* File: tb/backplane_model.sv */
// Purpose: Backplane bus: link clock and active-low frame pulse
// Assumes: Phase unrelated to the system clock
// Notes:   run_in low stops the clock; frame_ok_in low drops frames
`timescale 1ns/1ns
module backplane_model #(
    parameter int PERIOD_NS   = 800,
    parameter int FRAME_EVERY = 4
) (
    input  wire logic run_in,
    input  wire logic frame_ok_in,
    output logic      clock_8mhz_out,
    output logic      frame_pulse_n_out
);
    // ====================
    // Clock and frame generation
    int k;
    initial begin
        clock_8mhz_out = 1'h0;
        frame_pulse_n_out = 1'h1;
        k = 0;
        #37;
        forever begin
            #(PERIOD_NS / 2);
            if (run_in) begin
                clock_8mhz_out = ~clock_8mhz_out;
                if (clock_8mhz_out) begin
                    k = (k + 1) % FRAME_EVERY;
                    frame_pulse_n_out = !(frame_ok_in && k == 0);
                end
            end
        end
    end
endmodule

/* File: tb/test_tdm_bus_monitor_status_irq.sv */
// Purpose: Bench for the status and interrupt block
// Assumes: Frame window shortened to 8 link edges
// Notes:   Reset check, table rows, then event tests
`timescale 1ns/1ns
module test_tdm_bus_monitor_status_irq;
    typedef struct {logic [13:0] a; logic [15:0] wd; logic [15:0] exp;} row_s;
    logic        clk_in, sys_rst_in, avs_read_in, avs_write_in, irq_out, tdm_data_oe_out;
    logic [13:0] avs_address_in;
    logic [31:0] avs_writedata_in, avs_readdata_out, rd_v, rd_w, junk;
    logic        avs_waitrequest_out, adap_a, adap_b, sync_loss, run_a, run_b, ok_a, ok_b;
    logic        c8_a, c8_b, fr_a_n, fr_b_n;
    int          n_errors = 0, check_count = 0;
    row_s rows[6] = '{'{bus_monitor_pkg::ADDR_IRQ_ENABLE, 16'hFFFF, 16'hF1FF},
        '{bus_monitor_pkg::ADDR_IRQ_ENABLE, 16'h0000, 16'h0000},
        '{bus_monitor_pkg::ADDR_ALARM0_COMPARE, 16'h1234, 16'h1234},
        '{bus_monitor_pkg::ADDR_ALARM1_COMPARE, 16'h0001, 16'h0001},
        '{bus_monitor_pkg::ADDR_COUNT_HIGH, 16'hFFFF, 16'h0000},
        '{14'h0000, 16'hFFFF, 16'h0000}};

    // ====================
    // Clock, partners and design
    initial begin
        clk_in = 1'h0;
        forever #50 clk_in = ~clk_in;
    end
    backplane_model u_bus_a (.run_in(run_a), .frame_ok_in(ok_a), .clock_8mhz_out(c8_a),
        .frame_pulse_n_out(fr_a_n));
    backplane_model u_bus_b (.run_in(run_b), .frame_ok_in(ok_b), .clock_8mhz_out(c8_b),
        .frame_pulse_n_out(fr_b_n));
    tdm_bus_monitor_status_irq #(.FRAME_WINDOW(8)) u_dut (.clk_in, .sys_rst_in,
        .avs_address_in, .avs_read_in, .avs_write_in, .avs_writedata_in,
        .avs_byteenable_in(4'hF), .avs_readdata_out, .avs_waitrequest_out,
        .bus_a_frame_pulse_in(fr_a_n), .bus_b_frame_pulse_in(fr_b_n),
        .bus_a_8mhz_clock_in(c8_a), .bus_b_8mhz_clock_in(c8_b),
        .adap_a_point_lost_in(adap_a), .adap_b_point_lost_in(adap_b),
        .slave_sync_loss_in(sync_loss), .tdm_data_oe_out, .irq_out);

    // ====================
    // Shared tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
            n_errors++;
        end
    endtask
    task automatic xfer(input logic [13:0] a, input logic wr, input logic [15:0] wd,
                        output logic [31:0] rd);
        int n = 0;
        @(posedge clk_in);
        avs_address_in   <= a;
        avs_write_in     <= wr;
        avs_read_in      <= ~wr;
        avs_writedata_in <= {16'h0000, wd};
        do begin
            @(posedge clk_in);
            n++;
        end while (avs_waitrequest_out !== 1'h0 && n < 50);
        chk(32'(n == 50), 32'h0);
        rd = avs_readdata_out;
        avs_read_in  <= 1'h0;
        avs_write_in <= 1'h0;
    endtask
    task automatic rds();
        xfer(bus_monitor_pkg::ADDR_STATUS, 1'h0, 16'h0000, rd_v);
    endtask
    task automatic print_verdict();
        $display("checks=%0d errors=%0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // ====================
    // Main sequence
    initial begin
        {sys_rst_in, run_a, run_b, ok_a, ok_b} = 5'h1F;
        {avs_read_in, avs_write_in, adap_a, adap_b, sync_loss} = 5'h00;
        avs_address_in = 14'h0000;
        avs_writedata_in = 32'h0;
        repeat (3) @(posedge clk_in);
        sys_rst_in <= 1'h0;
        rds();
        chk(rd_v, 32'h00000100);
        chk(32'(tdm_data_oe_out), 32'h0);
        $display("test reset done");
        for (int i = 0; i < 6; i++) begin
            xfer(rows[i].a, 1'h1, rows[i].wd, junk);
            xfer(rows[i].a, 1'h0, 16'h0000, rd_v);
            chk(rd_v, {16'h0000, rows[i].exp});
        end
        $display("test table done");
        xfer(bus_monitor_pkg::ADDR_IRQ_ENABLE, 1'h1, 16'h00C0, junk);
        @(posedge clk_in);
        {adap_a, adap_b} <= 2'h3;
        @(posedge clk_in);
        {adap_a, adap_b} <= 2'h0;
        rds();
        chk(rd_v & 32'hC0, 32'hC0);
        chk(32'(irq_out), 32'h1);
        xfer(bus_monitor_pkg::ADDR_STATUS, 1'h1, 16'h0000, junk);
        xfer(bus_monitor_pkg::ADDR_STATUS, 1'h1, 16'h0040, junk);
        rds();
        chk(rd_v & 32'hC0, 32'h80);
        xfer(bus_monitor_pkg::ADDR_STATUS_CLEAR, 1'h1, 16'h0080, junk);
        @(posedge clk_in);
        chk(32'(irq_out), 32'h0);
        $display("test points done");
        xfer(bus_monitor_pkg::ADDR_ALARM0_COMPARE, 1'h1, 16'h0000, junk);
        xfer(bus_monitor_pkg::ADDR_ALARM1_COMPARE, 1'h1, 16'h0000, junk);
        rds();
        chk(rd_v & 32'h3, 32'h3);
        xfer(bus_monitor_pkg::ADDR_COUNT_LOW, 1'h0, 16'h0000, rd_v);
        xfer(bus_monitor_pkg::ADDR_COUNT_LOW, 1'h0, 16'h0000, rd_w);
        chk((rd_w - rd_v) & 32'hFFFF, 32'h3);
        $display("test alarm done");
        xfer(bus_monitor_pkg::ADDR_STATUS_CLEAR, 1'h1, 16'hFFFF, junk);
        repeat (2) @(posedge clk_in);
        chk(32'(tdm_data_oe_out), 32'h1);
        sync_loss <= 1'h1;
        @(posedge clk_in);
        sync_loss <= 1'h0;
        rds();
        chk(rd_v & 32'h100, 32'h100);
        chk(32'(tdm_data_oe_out), 32'h0);
        $display("test framing done");
        xfer(bus_monitor_pkg::ADDR_STATUS_CLEAR, 1'h1, 16'hFFFF, junk);
        repeat (2) @(posedge clk_in);
        {ok_a, run_b} <= 2'h0;
        repeat (200) @(posedge clk_in);
        rds();
        chk(rd_v & 32'hF13C, 32'h9124);
        chk(32'(tdm_data_oe_out), 32'h0);
        $display("test lines done");
        print_verdict();
    end

    // Watchdog
    initial begin
        repeat (20000) @(posedge clk_in);
        n_errors++;
        print_verdict();
    end
endmodule
